// ===== core/scmc_consts.svh
// offsets, field positions, reset values and counts of the system clock mode control
// Function
// R1 - divider field 000/001 picks low clock, 010..111 pick high/64 down to high/2
// R2 - high clock select bit set makes the undivided high clock the system clock
// R3 - moving the system clock from high to low stops the high oscillator
// R4 - fast wake bit lets the substitute clock run the system after wake-up
// R5 - low ready flag zero in all-off sleep, rises after 1024 or 1-2 cycles
// R6 - high ready flag low at power-on, sleep, clock-off idle; rises after 1024 cycles
// R7 - halt enters idle when idle enable is set, otherwise sleep
// R8 - idle clock keep bit keeps the system clock running while idle
// R9 - second control register bits 6 to 3 read as zero
// R10 - fast wake only from substitute sleep or clock-off idle, never all-off sleep
// R11 - crystal fast wake runs on substitute clock until high ready, then switches
// R12 - internal RC sources wake after their own ready count, fast wake ignored
// R13 - watchdog off means low oscillators off, so no fast wake from all-off sleep
// R14 - low voltage detect enabled turns an all-off sleep into substitute sleep
// R15 - source switching happens only on clock boundaries, no shortened pulses
// R16 - oscillator ready flags are synchronised before software can read them
`ifndef SCMC_CONSTS_SVH
`define SCMC_CONSTS_SVH

`define SCMC_ADDR_SYSTEM_MODE_CONTROL 8'h00
`define SCMC_ADDR_CTRL 8'h04
`define SCMC_ADDR_CFG 8'h08
`define SCMC_ADDR_STAT 8'h0c

`define SCMC_SYSTEM_MODE_CONTROL_RESET 8'h03
`define SCMC_CTRL_RESET 8'h00
`define SCMC_CFG_RESET 4'h0

`define SCMC_SYSTEM_MODE_CONTROL_DIV_MSB 7
`define SCMC_SYSTEM_MODE_CONTROL_DIV_LSB 5
`define SCMC_SYSTEM_MODE_CONTROL_FAST_BIT 4
`define SCMC_SYSTEM_MODE_CONTROL_IDLE_BIT 1
`define SCMC_SYSTEM_MODE_CONTROL_HCLK_BIT 0
`define SCMC_CTRL_KEEP_BIT 7
`define SCMC_CFG_MSB 3

`define SCMC_DIV_LOW_MAX 3'h1
`define SCMC_DIV_FIRST_HIGH 3'h2
`define SCMC_DIV_FULL_MASK 6'h3f

`define SCMC_HIGH_STABLE_CYCLES 1024
`define SCMC_LOW_XTAL_CYCLES 1024
`define SCMC_LOW_RC_CYCLES 2

`define SCMC_RESP_OKAY 2'b00
`define SCMC_RESP_SLVERR 2'b10

`endif

// ===== core/scmc_pin_sync.sv
// two-flop synchroniser for an oscillator pin with a rising edge pulse
`default_nettype none
module scmc_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic rise
);
  logic meta;
  logic sync;
  logic last;

  // meta feeds only sync; the edge is taken between sync and last
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
      rise <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      last <= sync;
      rise <= sync & ~last;
    end
  end
endmodule
`default_nettype wire

// ===== core/scmc_pkg.sv
// types shared by the system clock mode control
`default_nettype none
package scmc_pkg;

  typedef enum logic [2:0] {
    mode_run,
    mode_sleep_all_off,
    mode_sleep_substitute_on,
    mode_idle_clock_off,
    mode_idle_clock_on,
    mode_wake_wait,
    mode_fast_wake
  } scmc_mode_t;

  typedef struct packed {
    logic [2:0] clock_divider_select;
    logic fast_wake_enable;
    logic low_osc_ready;
    logic high_osc_ready;
    logic idle_enable;
    logic high_clock_select;
  } scmc_system_mode_control_t;

  typedef struct packed {
    logic low_voltage_detect_enable;
    logic watchdog_enable;
    logic low_is_crystal;
    logic high_is_crystal;
  } scmc_cfg_t;

endpackage
`default_nettype wire

// ===== core/scmc_ready_timer.sv
// counts oscillator cycles after start-up and raises a ready flag
`default_nettype none
module scmc_ready_timer #(
  parameter int CNT_W = 11
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic tick,
  input wire logic [CNT_W-1:0] target,
  output logic ready
);
  logic [CNT_W-1:0] count;

  // a stopped oscillator loses its ready state and restarts its count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      ready <= 1'b0;
    end else if (!run) begin
      count <= '0;
      ready <= 1'b0;
    end else if (tick && !ready) begin
      count <= count + 1'b1;
      if (count == target - 1'b1) begin
        ready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== core/scmc_top.sv
// system clock source selection, halt and wake-up modes, register slave
`include "scmc_consts.svh"
`default_nettype none
module scmc_top #(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 11,
  parameter int HIGH_STABLE = `SCMC_HIGH_STABLE_CYCLES,
  parameter int LOW_XTAL_STABLE = `SCMC_LOW_XTAL_CYCLES,
  parameter int LOW_RC_STABLE = `SCMC_LOW_RC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic high_osc_in,
  input wire logic low_osc_in,
  input wire logic halt_req,
  input wire logic wake_req,
  output logic sys_clk_en,
  output logic cpu_run,
  output logic high_osc_enable,
  output logic low_osc_enable,
  output scmc_pkg::scmc_mode_t power_mode
);
  import scmc_pkg::*;

  localparam logic [CNT_W-1:0] HIGH_TARGET = CNT_W'(HIGH_STABLE);
  localparam logic [CNT_W-1:0] LOW_XTAL_TARGET = CNT_W'(LOW_XTAL_STABLE);
  localparam logic [CNT_W-1:0] LOW_RC_TARGET = CNT_W'(LOW_RC_STABLE);

  scmc_system_mode_control_t system_mode_control;
  scmc_cfg_t cfg;
  logic idle_clock_keep;
  scmc_mode_t next_mode;
  logic high_tick;
  logic low_tick;
  logic high_ready;
  logic low_ready;
  logic [5:0] div_cnt;
  logic [2:0] active_div;
  logic active_hclk;
  logic req_high;
  logic active_high;
  logic target_ready;
  logic active_ok;
  logic active_tick;
  logic [5:0] div_mask;
  logic [CNT_W-1:0] low_target;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic do_write;
  logic [31:0] read_value;
  logic read_hit;

  // oscillator pins are foreign to clk; the ready flags come from counters on
  // synchronised edges, so software only ever sees clk-domain flags (see R16)
  scmc_pin_sync u_high_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(high_osc_in),
    .rise(high_tick)
  );

  scmc_pin_sync u_low_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(low_osc_in),
    .rise(low_tick)
  );

  // crystal and internal rc both need the same count on the high side (see R6)
  scmc_ready_timer #(.CNT_W(CNT_W)) u_high_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(high_osc_enable),
    .tick(high_tick),
    .target(HIGH_TARGET),
    .ready(high_ready)
  );

  assign low_target = cfg.low_is_crystal ? LOW_XTAL_TARGET : LOW_RC_TARGET; // see R5

  scmc_ready_timer #(.CNT_W(CNT_W)) u_low_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(low_osc_enable),
    .tick(low_tick),
    .target(low_target),
    .ready(low_ready)
  );

  // requested source comes from the register, active source is what runs now
  assign req_high = system_mode_control.high_clock_select | (system_mode_control.clock_divider_select > `SCMC_DIV_LOW_MAX);
  assign active_high = active_hclk | (active_div > `SCMC_DIV_LOW_MAX);
  assign target_ready = req_high ? high_ready : low_ready;
  assign active_ok = active_high ? high_ready : low_ready;
  assign div_mask = `SCMC_DIV_FULL_MASK >> (active_div - `SCMC_DIV_FIRST_HIGH); // see R1

  always_comb begin
    if (active_hclk) begin
      active_tick = high_tick; // see R2
    end else if (active_div > `SCMC_DIV_LOW_MAX) begin
      active_tick = high_tick && ((div_cnt & div_mask) == div_mask); // see R1
    end else begin
      active_tick = low_tick; // see R1
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 6'h00;
    end else if (high_tick) begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  // the new selection is taken right after a whole pulse of the old one, or at once while the old one is not ready,
  // and only once the new source is stable, so no short clock slips out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_div <= 3'(`SCMC_SYSTEM_MODE_CONTROL_RESET >> `SCMC_SYSTEM_MODE_CONTROL_DIV_LSB);
      active_hclk <= 1'(`SCMC_SYSTEM_MODE_CONTROL_RESET >> `SCMC_SYSTEM_MODE_CONTROL_HCLK_BIT);
    end else if ((active_tick || !active_ok) && target_ready) begin
      active_div <= system_mode_control.clock_divider_select; // see R15
      active_hclk <= system_mode_control.high_clock_select; // see R15
    end
  end

  // halt and wake sequencing
  always_comb begin
    next_mode = power_mode;
    unique case (power_mode)
      mode_run: begin
        if (halt_req) begin
          if (system_mode_control.idle_enable) begin
            next_mode = idle_clock_keep ? mode_idle_clock_on : mode_idle_clock_off; // see R7
          end else if (cfg.low_voltage_detect_enable || cfg.watchdog_enable) begin
            next_mode = mode_sleep_substitute_on; // see R14
          end else begin
            next_mode = mode_sleep_all_off; // see R7
          end
        end
      end
      mode_idle_clock_on: begin
        if (wake_req) begin
          next_mode = mode_run;
        end
      end
      mode_sleep_substitute_on, mode_idle_clock_off: begin
        if (wake_req) begin
          if (system_mode_control.fast_wake_enable && cfg.high_is_crystal && req_high) begin
            next_mode = mode_fast_wake; // see R4, R10
          end else begin
            next_mode = mode_wake_wait; // see R12
          end
        end
      end
      mode_sleep_all_off: begin
        // the substitute clock is stopped here, so the fast wake bit is moot
        if (wake_req) begin
          next_mode = mode_wake_wait; // see R10, R13
        end
      end
      mode_wake_wait: begin
        if (target_ready) begin
          next_mode = mode_run; // see R12
        end
      end
      mode_fast_wake: begin
        if (high_ready) begin
          next_mode = mode_run; // see R11
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_mode <= mode_run;
    end else begin
      power_mode <= next_mode;
    end
  end

  // oscillator enables follow the next mode so they change with the mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_osc_enable <= 1'b1;
      low_osc_enable <= 1'b1;
      cpu_run <= 1'b1;
    end else begin
      low_osc_enable <= (next_mode != mode_sleep_all_off); // see R5, R13
      cpu_run <= (next_mode == mode_run) || (next_mode == mode_fast_wake); // see R7
      unique case (next_mode)
        mode_run, mode_wake_wait, mode_fast_wake: begin
          high_osc_enable <= req_high || active_high; // see R3
        end
        mode_idle_clock_on: begin
          high_osc_enable <= active_high; // see R8
        end
        mode_sleep_all_off, mode_sleep_substitute_on, mode_idle_clock_off: begin
          high_osc_enable <= 1'b0; // see R6
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_clk_en <= 1'b0;
    end else begin
      unique case (power_mode)
        mode_run, mode_idle_clock_on: begin
          sys_clk_en <= active_tick && active_ok && !sys_clk_en; // see R8, R15
        end
        mode_fast_wake: begin
          sys_clk_en <= low_tick && low_ready; // see R11
        end
        mode_sleep_all_off, mode_sleep_substitute_on, mode_idle_clock_off,
        mode_wake_wait: begin
          sys_clk_en <= 1'b0;
        end
      endcase
    end
  end

  // axi4-lite write: address and data held until both are in, one at a time
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCMC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if ((aw_addr == `SCMC_ADDR_SYSTEM_MODE_CONTROL) || (aw_addr == `SCMC_ADDR_CTRL) ||
            (aw_addr == `SCMC_ADDR_CFG) || (aw_addr == `SCMC_ADDR_STAT)) begin
          s_axi_bresp <= `SCMC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `SCMC_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // only byte lane 0 carries register bits; the ready flags are never stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      system_mode_control <= `SCMC_SYSTEM_MODE_CONTROL_RESET;
      idle_clock_keep <= 1'(`SCMC_CTRL_RESET >> `SCMC_CTRL_KEEP_BIT);
      cfg <= `SCMC_CFG_RESET;
    end else if (do_write && w_lane0) begin
      if (aw_addr == `SCMC_ADDR_SYSTEM_MODE_CONTROL) begin
        system_mode_control.clock_divider_select <= w_data[`SCMC_SYSTEM_MODE_CONTROL_DIV_MSB:`SCMC_SYSTEM_MODE_CONTROL_DIV_LSB]; // see R1
        system_mode_control.fast_wake_enable <= w_data[`SCMC_SYSTEM_MODE_CONTROL_FAST_BIT]; // see R4
        system_mode_control.idle_enable <= w_data[`SCMC_SYSTEM_MODE_CONTROL_IDLE_BIT]; // see R7
        system_mode_control.high_clock_select <= w_data[`SCMC_SYSTEM_MODE_CONTROL_HCLK_BIT]; // see R2
      end
      if (aw_addr == `SCMC_ADDR_CTRL) begin
        idle_clock_keep <= w_data[`SCMC_CTRL_KEEP_BIT]; // see R8
      end
      if (aw_addr == `SCMC_ADDR_CFG) begin
        cfg <= w_data[`SCMC_CFG_MSB:0];
      end
    end
  end

  always_comb begin
    read_hit = 1'b1;
    read_value = 32'h00000000;
    unique case (s_axi_araddr)
      `SCMC_ADDR_SYSTEM_MODE_CONTROL: begin
        read_value = {24'h000000, system_mode_control.clock_divider_select, system_mode_control.fast_wake_enable,
                      low_ready, high_ready, system_mode_control.idle_enable,
                      system_mode_control.high_clock_select}; // see R5, R6
      end
      `SCMC_ADDR_CTRL: begin
        read_value = {24'h000000, idle_clock_keep, 7'h00}; // see R9
      end
      `SCMC_ADDR_CFG: begin
        read_value = {28'h0000000, cfg};
      end
      `SCMC_ADDR_STAT: begin
        read_value = {29'h0, power_mode};
      end
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SCMC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_value;
      s_axi_rresp <= read_hit ? `SCMC_RESP_OKAY : `SCMC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== dv/scmc_top_checker.sv
// port assertions for the system clock mode control
`default_nettype none
module scmc_top_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic sys_clk_en,
  input wire logic cpu_run,
  input wire logic high_osc_enable,
  input wire logic low_osc_enable,
  input wire scmc_pkg::scmc_mode_t power_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  import scmc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_HALT_ENTERS_LOW_POWER: assert property (
    halt_req && power_mode == mode_run |=> !cpu_run &&
      power_mode inside {[mode_sleep_all_off:mode_idle_clock_on]})
    else $error("halt did not stop the cpu");
  AST_CPU_OFF_WHILE_HALTED: assert property (
    power_mode inside {[mode_sleep_all_off:mode_wake_wait]} |-> !cpu_run)
    else $error("cpu running in a halted mode");
  AST_ALL_OFF_STOPS_OSCS: assert property (
    power_mode == mode_sleep_all_off |-> !low_osc_enable && !high_osc_enable)
    else $error("oscillator left on in all-off sleep");
  AST_NO_CLOCK_WHEN_STOPPED: assert property (
    power_mode inside {[mode_sleep_all_off:mode_idle_clock_off]} && $stable(power_mode)
      |-> !sys_clk_en)
    else $error("system clock pulse while stopped");
  AST_IDLE_KEEPS_CLOCK: assert property (
    $rose(power_mode == mode_idle_clock_on) |-> ##[1:40] sys_clk_en)
    else $error("no system clock in idle with clock kept");
  AST_ALL_OFF_WAKE_WAITS: assert property (
    power_mode == mode_sleep_all_off && wake_req |=> power_mode == mode_wake_wait)
    else $error("all-off sleep did not wake through the wait state");
  AST_FAST_WAKE_ON_SUBSTITUTE: assert property (
    power_mode == mode_fast_wake |-> cpu_run && low_osc_enable && high_osc_enable)
    else $error("fast wake without cpu or oscillators");
  AST_FAST_WAKE_BOUNDED: assert property (
    $rose(power_mode == mode_fast_wake) |-> ##[1:200] power_mode == mode_run)
    else $error("fast wake never handed over to run");
  AST_WAKE_WAIT_TO_RUN: assert property (
    power_mode == mode_wake_wait ##1 power_mode != mode_wake_wait
      |-> power_mode == mode_run && cpu_run)
    else $error("wake wait left to a mode other than run");
  AST_CLK_EN_SINGLE: assert property (
    sys_clk_en |=> !sys_clk_en)
    else $error("system clock pulse longer than one cycle");
endmodule
bind scmc_top scmc_top_checker u_scmc_top_checker (.clk, .rst_n, .halt_req, .wake_req,
  .sys_clk_en, .cpu_run, .high_osc_enable, .low_osc_enable, .power_mode);
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the system clock mode control
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scmc_pkg::*;
  logic clk, rst_n, high_osc_in, low_osc_in, halt_req, wake_req, armed;
  logic [7:0] s_axi_awaddr, s_axi_araddr, v;
  logic [2:0] s_axi_awprot, s_axi_arprot, lc;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, hc;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic sys_clk_en, cpu_run, high_osc_enable, low_osc_enable;
  scmc_mode_t power_mode;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [2:0] pq[$];
  int iq[$];
  int error_cnt, comparisons, seed, cnt, p;

  // short ready counts keep the wake-up waits brief
  scmc_top #(.HIGH_STABLE(4), .LOW_XTAL_STABLE(4), .LOW_RC_STABLE(2)) u_scmc_top (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_osc_in, .low_osc_in,
    .halt_req, .wake_req, .sys_clk_en, .cpu_run, .high_osc_enable, .low_osc_enable,
    .power_mode);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // oscillators stand still while disabled, so a restart really costs edges
  always @(posedge clk) begin
    if (high_osc_enable) begin
      hc <= (hc == 2'h2) ? 2'h0 : hc + 2'h1;
      if (hc == 2'h2) high_osc_in <= ~high_osc_in;
    end
    if (low_osc_enable) begin
      lc <= (lc == 3'h6) ? 3'h0 : lc + 3'h1;
      if (lc == 3'h6) low_osc_in <= ~low_osc_in;
    end
  end

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp(34'(s_axi_bresp), 34'(bq.pop_front()));
    if (pq.size() > 0) cmp(34'({high_osc_enable, low_osc_enable, cpu_run}), 34'(pq.pop_front()));
    cnt <= sys_clk_en ? 1 : cnt + 1;
    // first pulse after a note only arms, the next one closes a whole period
    if (sys_clk_en && iq.size() > 0) begin
      if (armed) cmp(34'(cnt), 34'(iq.pop_front()));
      armed <= !armed;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    bq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_awprot <= 3'($random(seed));
    s_axi_wdata <= {24'($random(seed)), d};
    s_axi_wstrb <= 4'($random(seed)) | 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arprot <= 3'($random(seed));
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
  endtask

  // halt, optional flag read, wake, then back in run
  task automatic hw(input logic [7:0] sm, ct, cf, input logic [2:0] mh, mw,
                    input logic [7:0] ms);
    wr(8'h00, sm, 2'h0);
    wr(8'h04, ct, 2'h0);
    wr(8'h08, cf, 2'h0);
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    rd(8'h0c, 34'(mh));
    pq.push_back({mh == mode_idle_clock_on, mh != mode_sleep_all_off, 1'b0});
    if (ms != 8'hff) rd(8'h00, 34'(ms));
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    if (mw != 3'h7) rd(8'h0c, 34'(mw));
    repeat (150) @(posedge clk);
    rd(8'h0c, 34'h0);
  endtask

  task automatic print_verdict;
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    print_verdict;
  end

  initial begin
    seed = 32'h5651ad62;
    {rst_n, halt_req, wake_req, high_osc_in, low_osc_in, hc, lc, armed} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    {cnt, p, v, error_cnt, comparisons} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h00, 34'h03);
    rd(8'h04, 34'h00);
    repeat (100) @(posedge clk);
    rd(8'h00, 34'h0f);
    wr(8'h04, 8'hff, 2'h0);
    rd(8'h04, 34'h80);
    wr(8'h10, 8'h5a, 2'h2);
    rd(8'h10, 34'h200000000);
    for (int d = 0; d < 9; d++) begin
      v = (d == 8) ? 8'h01 : {3'(d), 5'h00};
      p = (d == 8) ? 6 : (d < 2) ? 14 : 6 << (8 - d);
      wr(8'h00, v, 2'h0);
      repeat (2 * p + 60) @(posedge clk);
      iq.push_back(p);
      while (iq.size() > 0) @(posedge clk);
      if (d == 0) pq.push_back(3'h3);
    end
    hw(8'h03, 8'h80, 8'h00, mode_idle_clock_on, 3'h7, 8'hff);
    hw(8'h03, 8'h00, 8'h00, mode_idle_clock_off, mode_wake_wait, 8'hff);
    hw(8'h01, 8'h00, 8'h00, mode_sleep_all_off, mode_wake_wait, 8'h01);
    hw(8'h01, 8'h00, 8'h08, mode_sleep_substitute_on, mode_wake_wait, 8'hff);
    hw(8'h11, 8'h00, 8'h05, mode_sleep_substitute_on, mode_fast_wake, 8'hff);
    hw(8'h11, 8'h00, 8'h01, mode_sleep_all_off, mode_wake_wait, 8'hff);
    hw(8'h11, 8'h00, 8'h04, mode_sleep_substitute_on, mode_wake_wait, 8'hff);
    hw(8'h13, 8'h00, 8'h01, mode_idle_clock_off, mode_fast_wake, 8'hff);
    print_verdict;
  end
endmodule
`default_nettype wire
